// ==== startup_seq_cfg.svh ====
// constants of the dual rail start-up sequencer: timing counts and codes
// assumes a 100 MHz system clock
`ifndef STARTUP_SEQ_CFG_SVH
`define STARTUP_SEQ_CFG_SVH
`define CLK_PERIOD_NS 10
`define STARTUP_DELAY_US 100
`define STARTUP_DELAY_CYC ((`STARTUP_DELAY_US * 1000) / `CLK_PERIOD_NS)
// ramp rate 3.25 mV/us with 1 mV reference steps: one step per 1000/3.25 ns, rounded down
`define RAMP_RATE_UV_PER_US 3250
`define RAMP_STEP_CYC ((1000000 / `RAMP_RATE_UV_PER_US) * 1000 / `CLK_PERIOD_NS / 1000)
`define RETRY_WAIT_MS 12
`define RETRY_WAIT_CYC ((`RETRY_WAIT_MS * 1000000) / `CLK_PERIOD_NS)
`define RETRY_LIMIT 3'd7
`define UV_TRIP_MV 16'd300
`define UV_CLEAR_MV 16'd250
`define OVP_RELEASE_MV 16'd400
`define TARGET_RESET 16'h0000
`endif

// ==== startup_seq_pkg.sv ====
// types shared by the sequencer files
package startup_seq_pkg;
   typedef enum logic [1:0] {PHASES_FOUR, PHASES_THREE, PHASES_TWO} phase_count_e;
   typedef logic [15:0] millivolt_t;
endpackage : startup_seq_pkg

// ==== pin_sync.sv ====
// three flop synchroniser for one pin; a change is accepted once stages two and three agree
// assumes the pin is asynchronous to sys_clk_i
`timescale 1ns/100ps
module pin_sync (
   input wire logic sys_clk_i,
   input wire logic srst_i,
   input wire logic pin_i,
   output logic level_o
);
   logic s1_r;
   logic s2_r;
   logic s3_r;
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
         level_o <= 1'b0;
      end else begin
         s1_r <= pin_i;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (s2_r == s3_r) begin
            level_o <= s3_r;
         end
      end
   end
endmodule : pin_sync

// ==== dual_rail_startup_fault_sequencer.sv ====
// start-up, soft-start ramp and protection sequencer for core and aux rails
// assumes analogue comparators give digital levels and targets arrive as millivolt codes
// Behaviour
// R1: start only when all start conditions met
// R2: evaluate other inputs after bias good
// R3: shutdown until enable comparator high, hysteretic
// R4: latch target mode on enable rise
// R5: fourth sense high three, both two
// R6: sample phase count before soft-start
// R7: serial mode both rails, parallel core only
// R8: serial targets held until enable low
// R9: load targets, wait fixed startup delay
// R10: ramp references at fixed slew rate
// R11: power ok only after ramp done
// R12: drives off while feedback above reference
// R13: precharged above target: drive at end
// R14: power ok low in shutdown, soft-start
// R15: drop power ok on faults or disable
// R16: overvoltage, overcurrent latch keeps power low
// R17: overvoltage forces all low sides on
// R18: low sides on until sense below 400mV
// R19: after overvoltage, stay off until reset
// R20: system readies drivers before enable
// R21: continuously compare sense to overvoltage trip; code ignores the overvoltage inputs while in ST_OFF
// R22: undervoltage flag with 300/250 mV hysteresis
// R23: overcurrent waits 12ms, seven tries latch
// R24: no sense tie-high gives four phases
`timescale 1ns/100ps
`include "startup_seq_cfg.svh"
module dual_rail_startup_fault_sequencer
   import startup_seq_pkg::*;
#(
   parameter int unsigned STARTUP_DELAY_CYC = `STARTUP_DELAY_CYC,
   parameter int unsigned RETRY_WAIT_CYC = `RETRY_WAIT_CYC
) (
   input wire logic sys_clk_i,
   input wire logic srst_i,
   input wire logic bias_por_ok_i,
   input wire logic core_driver_supply_ok_i,
   input wire logic aux_rail_driver_supply_ok_i,
   input wire logic enable_cmp_i,
   input wire logic mode_select_input_i,
   input wire logic phase_three_sense_neg_high_i,
   input wire logic phase_four_sense_neg_high_i,
   input wire logic fixed_target_enable_i,
   input wire logic serial_target_data_i,
   input wire logic serial_target_clock_i,
   input wire startup_seq_pkg::millivolt_t parallel_target_mv_i,
   input wire startup_seq_pkg::millivolt_t serial_core_target_mv_i,
   input wire startup_seq_pkg::millivolt_t serial_aux_target_mv_i,
   input wire logic core_fb_above_ref_i,
   input wire logic aux_rail_fb_above_ref_i,
   input wire startup_seq_pkg::millivolt_t core_sense_mv_i,
   input wire startup_seq_pkg::millivolt_t aux_rail_sense_mv_i,
   input wire logic core_ov_i,
   input wire logic aux_rail_ov_i,
   input wire logic core_oc_i,
   input wire logic aux_rail_oc_i,
   input wire startup_seq_pkg::millivolt_t differential_sense_out_mv_i,
   output startup_seq_pkg::millivolt_t core_ref_mv_o,
   output startup_seq_pkg::millivolt_t aux_rail_ref_mv_o,
   output logic core_drive_en_o,
   output logic aux_rail_drive_en_o,
   output logic low_side_force_o,
   output logic serial_target_mode_o,
   output startup_seq_pkg::phase_count_e phase_count_o,
   output logic ext_pwm3_active_o,
   output logic ext_pwm4_active_o,
   output logic power_ok_out_o,
   output logic power_ok_out_oe_n_o,
   output logic latched_off_o
);
   import startup_seq_pkg::*;
   typedef enum logic [2:0] {ST_OFF, ST_DELAY, ST_RAMP, ST_RUN, ST_OC_WAIT, ST_LATCHED} seq_state_e;
   ////////////////////////////////////////////////////////////////////////////////
   // input synchronisers; phase tie inputs and mode select are straps, sampled here too
   localparam int NSYNC = 7;
   logic [NSYNC-1:0] raw_pins;
   logic [NSYNC-1:0] sync_pins;
   assign raw_pins = {mode_select_input_i, bias_por_ok_i, core_driver_supply_ok_i,
                      aux_rail_driver_supply_ok_i, enable_cmp_i, phase_three_sense_neg_high_i,
                      phase_four_sense_neg_high_i};
   generate
      for (genvar gi = 0; gi < NSYNC; gi++) begin : g_sync
         pin_sync u_sync (
            .sys_clk_i(sys_clk_i),
            .srst_i(srst_i),
            .pin_i(raw_pins[gi]),
            .level_o(sync_pins[gi])
         );
      end
   endgenerate
   logic bias_ok;
   logic drv_ok;
   logic en_lvl;
   logic p3_high;
   logic p4_high;
   assign bias_ok = sync_pins[5];
   // driver supplies, enable and phase detect only count once bias is up [R2]
   assign drv_ok = bias_ok & sync_pins[4] & sync_pins[3];
   // enable comparator already applies the 0.86 V rise / 110 mV hysteresis [R3]
   assign en_lvl = bias_ok & sync_pins[2];
   assign p3_high = bias_ok & sync_pins[1];
   assign p4_high = bias_ok & sync_pins[0];

   logic mode_sel;
   assign mode_sel = sync_pins[6];

   ////////////////////////////////////////////////////////////////////////////////
   // enable edge, mode latch, target capture
   logic en_prev_r;
   logic en_rise;
   assign en_rise = en_lvl & ~en_prev_r;
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         en_prev_r <= 1'b0;
      end else begin
         en_prev_r <= en_lvl;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         serial_target_mode_o <= 1'b0;
      end else if (en_rise) begin
         serial_target_mode_o <= mode_sel; // [R4]
      end
   end

   // fixed-target, data and clock levels are decoded outside into millivolt targets
   millivolt_t core_tgt_r;
   millivolt_t aux_tgt_r;
   logic tgt_valid_r;
   always_ff @(posedge sys_clk_i) begin
      if (srst_i || !en_lvl) begin
         core_tgt_r <= `TARGET_RESET;
         aux_tgt_r <= `TARGET_RESET;
         tgt_valid_r <= 1'b0;
      end else if (!tgt_valid_r && en_prev_r) begin
         // capture once per enable; held until enable low or reset [R8]
         tgt_valid_r <= 1'b1;
         if (serial_target_mode_o) begin
            core_tgt_r <= serial_core_target_mv_i;
            aux_tgt_r <= serial_aux_target_mv_i; // [R7]
         end else begin
            core_tgt_r <= parallel_target_mv_i;
            aux_tgt_r <= `TARGET_RESET; // [R7]
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // sequencer
   seq_state_e state_r;
   logic [31:0] cnt_r;
   logic [2:0] retry_r;
   logic ov_any;
   logic oc_any;
   logic start_ok;
   logic ramp_done;
   logic step_tick;
   assign ov_any = core_ov_i | aux_rail_ov_i; // [R21]
   assign oc_any = core_oc_i | aux_rail_oc_i;
   assign start_ok = bias_ok & drv_ok & en_lvl & tgt_valid_r; // [R1]
   assign ramp_done = (core_ref_mv_o == core_tgt_r) && (aux_rail_ref_mv_o == aux_tgt_r);
   assign step_tick = (cnt_r >= 32'(`RAMP_STEP_CYC - 1));

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         state_r <= ST_OFF;
         cnt_r <= 32'h0;
         retry_r <= 3'h0;
      end else if (state_r == ST_LATCHED) begin
         state_r <= ST_LATCHED; // only reset leaves [R16] [R19]
      end else if (ov_any && state_r != ST_OFF) begin
         state_r <= ST_LATCHED; // [R16]
      end else if (!bias_ok || !en_lvl) begin
         state_r <= ST_OFF;
         retry_r <= 3'h0;
         cnt_r <= 32'h0;
      end else if (oc_any && state_r inside {ST_DELAY, ST_RAMP, ST_RUN}) begin
         state_r <= ST_OC_WAIT; // [R23]
         cnt_r <= 32'h0;
      end else begin
         case (state_r)
            ST_OFF: begin
               cnt_r <= 32'h0;
               if (start_ok) begin
                  state_r <= ST_DELAY;
               end
            end
            ST_DELAY: begin
               if (cnt_r == STARTUP_DELAY_CYC - 1) begin
                  state_r <= ST_RAMP; // [R9]
                  cnt_r <= 32'h0;
               end else begin
                  cnt_r <= cnt_r + 32'h1;
               end
            end
            ST_RAMP: begin
               if (ramp_done) begin
                  state_r <= ST_RUN;
                  retry_r <= 3'h0;
               end else begin
                  cnt_r <= step_tick ? 32'h0 : cnt_r + 32'h1;
               end
            end
            ST_RUN: state_r <= ST_RUN;
            ST_OC_WAIT: begin
               if (cnt_r == RETRY_WAIT_CYC - 1) begin
                  cnt_r <= 32'h0;
                  if (retry_r == `RETRY_LIMIT - 3'd1) begin
                     state_r <= ST_LATCHED; // [R23]
                  end else begin
                     retry_r <= retry_r + 3'h1;
                     state_r <= ST_DELAY; // [R23]
                  end
               end else begin
                  cnt_r <= cnt_r + 32'h1;
               end
            end
            default: state_r <= ST_OFF;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // phase count, sampled while stopped and frozen from soft-start on [R6]
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         phase_count_o <= PHASES_FOUR;
         ext_pwm3_active_o <= 1'b1;
         ext_pwm4_active_o <= 1'b1;
      end else if (state_r == ST_OFF) begin
         if (p3_high && p4_high) begin
            phase_count_o <= PHASES_TWO; // [R5]
            ext_pwm3_active_o <= 1'b0;
            ext_pwm4_active_o <= 1'b0;
         end else if (p4_high) begin
            phase_count_o <= PHASES_THREE; // [R5]
            ext_pwm3_active_o <= 1'b1;
            ext_pwm4_active_o <= 1'b0;
         end else begin
            phase_count_o <= PHASES_FOUR; // [R24]
            ext_pwm3_active_o <= 1'b1;
            ext_pwm4_active_o <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // references: zero until ramp, then one millivolt per step
   always_ff @(posedge sys_clk_i) begin
      if (srst_i || !(state_r == ST_RAMP || state_r == ST_RUN)) begin
         core_ref_mv_o <= 16'h0;
         aux_rail_ref_mv_o <= 16'h0;
      end else if (state_r == ST_RAMP && step_tick) begin
         if (core_ref_mv_o < core_tgt_r) begin
            core_ref_mv_o <= core_ref_mv_o + 16'h1; // [R10]
         end
         if (aux_rail_ref_mv_o < aux_tgt_r) begin
            aux_rail_ref_mv_o <= aux_rail_ref_mv_o + 16'h1; // [R10]
         end
      end
   end

   // drive enable: during ramp only once reference passes feedback; pre-bias above
   // target is released at ramp end; overvoltage drops both with the clamp [R12] [R13] [R17]
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         core_drive_en_o <= 1'b0;
         aux_rail_drive_en_o <= 1'b0;
      end else if (state_r == ST_RUN && !ov_any) begin
         core_drive_en_o <= 1'b1; // [R13]
         aux_rail_drive_en_o <= serial_target_mode_o;
      end else if (state_r == ST_RAMP && !ov_any) begin
         core_drive_en_o <= core_drive_en_o | ~core_fb_above_ref_i; // [R12]
         aux_rail_drive_en_o <= serial_target_mode_o
                                & (aux_rail_drive_en_o | ~aux_rail_fb_above_ref_i);
      end else begin
         core_drive_en_o <= 1'b0;
         aux_rail_drive_en_o <= 1'b0;
      end
   end

   // overvoltage clamp: low sides on while sense stays at or above 400 mV, rearmed on recurrence
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         low_side_force_o <= 1'b0;
      end else if (ov_any && state_r != ST_OFF) begin
         low_side_force_o <= 1'b1; // [R17]
      end else if (differential_sense_out_mv_i < `OVP_RELEASE_MV) begin
         low_side_force_o <= 1'b0; // [R18]
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         latched_off_o <= 1'b0;
      end else begin
         latched_off_o <= (state_r == ST_LATCHED);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // undervoltage flags with hysteresis [R22]
   logic [1:0] uv_r;
   millivolt_t sense_mv [2];
   millivolt_t tgt_mv [2];
   assign sense_mv[0] = core_sense_mv_i;
   assign sense_mv[1] = aux_rail_sense_mv_i;
   assign tgt_mv[0] = core_tgt_r;
   assign tgt_mv[1] = aux_tgt_r;
   generate
      for (genvar gi = 0; gi < 2; gi++) begin : g_uv
         always_ff @(posedge sys_clk_i) begin
            if (srst_i || state_r != ST_RUN || (gi == 1 && !serial_target_mode_o)) begin
               uv_r[gi] <= 1'b0;
            end else if ({1'b0, sense_mv[gi]} + {1'b0, `UV_TRIP_MV} < {1'b0, tgt_mv[gi]}) begin
               uv_r[gi] <= 1'b1; // [R22]
            end else if ({1'b0, sense_mv[gi]} + {1'b0, `UV_CLEAR_MV} > {1'b0, tgt_mv[gi]}) begin
               uv_r[gi] <= 1'b0; // [R22]
            end
         end
      end
   endgenerate

   // power ok: open drain, oe_n low pulls the pin low [R14] [R15] [R11]
   logic pok_nxt;
   assign pok_nxt = (state_r == ST_RUN) && ramp_done && !uv_r[0] && !uv_r[1] && !ov_any && !oc_any
                    && en_lvl && bias_ok;
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         power_ok_out_o <= 1'b0;
         power_ok_out_oe_n_o <= 1'b0;
      end else begin
         power_ok_out_o <= 1'b0;
         power_ok_out_oe_n_o <= pok_nxt; // [R15] [R16]
      end
   end
endmodule : dual_rail_startup_fault_sequencer

// ==== startup_seq_monitor.sv ====
// port checker for the dual rail start-up sequencer
// assumes one clock domain with synchronous reset srst_i
`timescale 1ns/100ps
module startup_seq_monitor
   import startup_seq_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic srst_i,
   input wire logic core_ov_i,
   input wire startup_seq_pkg::millivolt_t parallel_target_mv_i,
   input wire startup_seq_pkg::millivolt_t serial_core_target_mv_i,
   input wire startup_seq_pkg::millivolt_t differential_sense_out_mv_i,
   input wire startup_seq_pkg::millivolt_t core_ref_mv_o,
   input wire startup_seq_pkg::millivolt_t aux_rail_ref_mv_o,
   input wire logic core_drive_en_o,
   input wire logic aux_rail_drive_en_o,
   input wire logic low_side_force_o,
   input wire logic serial_target_mode_o,
   input wire startup_seq_pkg::phase_count_e phase_count_o,
   input wire logic ext_pwm3_active_o,
   input wire logic ext_pwm4_active_o,
   input wire logic power_ok_out_oe_n_o,
   input wire logic latched_off_o
);
   default clocking @(posedge sys_clk_i);
   endclocking
   default disable iff (srst_i);
   ////////////////////////////////////////////////////////////////////////////////
   pg_after_ramp_a: assert property ($rose(power_ok_out_oe_n_o) |-> core_ref_mv_o ==
      (serial_target_mode_o ? serial_core_target_mv_i : parallel_target_mv_i))
      else $error("power ok released before ramp end");
   ref_slew_a: assert property (core_ref_mv_o > $past(core_ref_mv_o) |->
      core_ref_mv_o == $past(core_ref_mv_o) + 16'h0001)
      else $error("reference stepped by more than one");
   ov_clamp_a: assert property (core_ov_i && core_drive_en_o |=> low_side_force_o)
      else $error("overvoltage did not force low sides");
   clamp_safe_a: assert property (low_side_force_o |-> !power_ok_out_oe_n_o &&
      !core_drive_en_o && !aux_rail_drive_en_o)
      else $error("clamp with drives or power ok");
   clamp_hold_a: assert property (low_side_force_o &&
      differential_sense_out_mv_i >= 16'h0190 |=> low_side_force_o)
      else $error("clamp released above release level");
   latch_hold_a: assert property (latched_off_o |=> latched_off_o &&
      !power_ok_out_oe_n_o)
      else $error("latched off state left");
   aux_parallel_a: assert property (!serial_target_mode_o |->
      !aux_rail_drive_en_o && aux_rail_ref_mv_o == 16'h0000)
      else $error("aux rail active in parallel mode");
   phase_two_a: assert property (phase_count_o == PHASES_TWO |->
      !ext_pwm3_active_o && !ext_pwm4_active_o)
      else $error("two phase with external outputs active");
   phase_three_a: assert property (phase_count_o == PHASES_THREE |->
      ext_pwm3_active_o && !ext_pwm4_active_o)
      else $error("three phase output set wrong");
   phase_four_a: assert property (phase_count_o == PHASES_FOUR |->
      ext_pwm3_active_o && ext_pwm4_active_o)
      else $error("four phase output set wrong");
endmodule : startup_seq_monitor

bind dual_rail_startup_fault_sequencer startup_seq_monitor mon (
   .sys_clk_i(sys_clk_i), .srst_i(srst_i), .core_ov_i(core_ov_i),
   .parallel_target_mv_i(parallel_target_mv_i),
   .serial_core_target_mv_i(serial_core_target_mv_i),
   .differential_sense_out_mv_i(differential_sense_out_mv_i),
   .core_ref_mv_o(core_ref_mv_o), .aux_rail_ref_mv_o(aux_rail_ref_mv_o),
   .core_drive_en_o(core_drive_en_o), .aux_rail_drive_en_o(aux_rail_drive_en_o),
   .low_side_force_o(low_side_force_o), .serial_target_mode_o(serial_target_mode_o),
   .phase_count_o(phase_count_o), .ext_pwm3_active_o(ext_pwm3_active_o),
   .ext_pwm4_active_o(ext_pwm4_active_o), .power_ok_out_oe_n_o(power_ok_out_oe_n_o),
   .latched_off_o(latched_off_o));

// ==== rail_partner_model.sv ====
// system sequencing and rail model: supplies, enable and the two output rails
// assumes the sequencer's drive enables and references at its ports
`timescale 1ns/100ps
module rail_partner_model
   import startup_seq_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic srst_i,
   input wire logic power_up_i,
   input wire startup_seq_pkg::millivolt_t droop_mv_i,
   input wire startup_seq_pkg::millivolt_t core_ref_mv_i,
   input wire startup_seq_pkg::millivolt_t aux_ref_mv_i,
   input wire logic core_drive_en_i,
   input wire logic aux_drive_en_i,
   output logic supplies_ok_o,
   output logic enable_o,
   output logic core_fb_above_o,
   output logic aux_fb_above_o,
   output startup_seq_pkg::millivolt_t core_sense_o,
   output startup_seq_pkg::millivolt_t aux_sense_o
);
   logic [3:0] en_wait_r;
   assign supplies_ok_o = power_up_i;
   // drivers are powered well before enable is raised
   always_ff @(posedge sys_clk_i) begin
      if (srst_i || !power_up_i) begin
         en_wait_r <= 4'h0;
         enable_o <= 1'b0;
      end else if (en_wait_r != 4'hf) begin
         en_wait_r <= en_wait_r + 4'h1;
      end else begin
         enable_o <= 1'b1;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // undriven rails keep their charge, so a later start is pre-biased
   always_ff @(posedge sys_clk_i) begin
      if (core_drive_en_i) begin
         core_sense_o <= (core_ref_mv_i > droop_mv_i) ? core_ref_mv_i - droop_mv_i : 16'h0000;
      end
      if (aux_drive_en_i) begin
         aux_sense_o <= aux_ref_mv_i;
      end
   end
   initial begin
      core_sense_o = 16'h0000;
      aux_sense_o = 16'h0000;
   end
   assign core_fb_above_o = core_sense_o > core_ref_mv_i;
   assign aux_fb_above_o = aux_sense_o > aux_ref_mv_i;
endmodule : rail_partner_model

// ==== tb_top.sv ====
// self-checking bench of the dual rail start-up sequencer
// assumes the partner model supplies enable and rail feedback
`timescale 1ns/100ps
module tb_top;
   import startup_seq_pkg::*;
   localparam int unsigned DLY = 20;
   localparam int unsigned STEP = 30;
   logic sys_clk, srst, power_up, mode_sel, ph3, ph4, core_ov, aux_ov, core_oc;
   millivolt_t par_tgt, ser_core, ser_aux, droop, diff_mv;
   millivolt_t core_sense, aux_sense, core_ref, aux_ref;
   logic sup_ok, en, core_fb, aux_fb, core_drv, aux_drv, ls_force, ser_mode;
   logic pwm3, pwm4, pg_pin, pg_oe_n, latched;
   phase_count_e ph_cnt;
   int errors = 0;
   int checked = 0;
   int n;
   rail_partner_model partner (.sys_clk_i(sys_clk), .srst_i(srst), .power_up_i(power_up),
      .droop_mv_i(droop), .core_ref_mv_i(core_ref), .aux_ref_mv_i(aux_ref),
      .core_drive_en_i(core_drv), .aux_drive_en_i(aux_drv), .supplies_ok_o(sup_ok),
      .enable_o(en), .core_fb_above_o(core_fb), .aux_fb_above_o(aux_fb),
      .core_sense_o(core_sense), .aux_sense_o(aux_sense));
   dual_rail_startup_fault_sequencer #(.STARTUP_DELAY_CYC(DLY), .RETRY_WAIT_CYC(50)) dut (
      .sys_clk_i(sys_clk), .srst_i(srst), .bias_por_ok_i(sup_ok),
      .core_driver_supply_ok_i(sup_ok), .aux_rail_driver_supply_ok_i(sup_ok),
      .enable_cmp_i(en), .mode_select_input_i(mode_sel), .phase_three_sense_neg_high_i(ph3),
      .phase_four_sense_neg_high_i(ph4), .fixed_target_enable_i(1'b0),
      .serial_target_data_i(1'b0), .serial_target_clock_i(1'b0),
      .parallel_target_mv_i(par_tgt), .serial_core_target_mv_i(ser_core),
      .serial_aux_target_mv_i(ser_aux), .core_fb_above_ref_i(core_fb),
      .aux_rail_fb_above_ref_i(aux_fb), .core_sense_mv_i(core_sense),
      .aux_rail_sense_mv_i(aux_sense), .core_ov_i(core_ov), .aux_rail_ov_i(aux_ov),
      .core_oc_i(core_oc), .aux_rail_oc_i(1'b0), .differential_sense_out_mv_i(diff_mv),
      .core_ref_mv_o(core_ref), .aux_rail_ref_mv_o(aux_ref), .core_drive_en_o(core_drv),
      .aux_rail_drive_en_o(aux_drv), .low_side_force_o(ls_force),
      .serial_target_mode_o(ser_mode), .phase_count_o(ph_cnt), .ext_pwm3_active_o(pwm3),
      .ext_pwm4_active_o(pwm4), .power_ok_out_o(pg_pin), .power_ok_out_oe_n_o(pg_oe_n),
      .latched_off_o(latched));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : end_of_test
   task automatic wait_pg(input logic lvl, output int cnt);
      cnt = 0;
      while (pg_oe_n !== lvl) begin
         @(negedge sys_clk);
         cnt++;
         if (cnt > 20000) begin
            chk("power ok wait", {15'h0, pg_oe_n}, {15'h0, lvl});
            end_of_test();
         end
      end
   endtask : wait_pg
   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_parallel;
      int lo;
      lo = 16 + DLY + 400 * STEP;
      @(posedge sys_clk) power_up <= 1'b1;
      wait_pg(1'b1, n);
      chk("start time", 16'(n >= lo && n <= lo + 40), 16'h1);
      chk("core ref", core_ref, 16'd400);
      chk("aux drive", {15'h0, aux_drv}, 16'h0);
      @(posedge sys_clk) mode_sel <= 1'b1;
      repeat (10) @(negedge sys_clk);
      chk("mode", {15'h0, ser_mode}, 16'h0);
      @(posedge sys_clk) droop <= 16'd310;
      wait_pg(1'b0, n);
      @(posedge sys_clk) droop <= 16'd270;
      repeat (20) @(negedge sys_clk);
      chk("uv hysteresis", {15'h0, pg_oe_n}, 16'h0);
      @(posedge sys_clk) droop <= 16'd240;
      wait_pg(1'b1, n);
      chk("uv clear drives", {15'h0, core_drv}, 16'h1);
      @(posedge sys_clk) droop <= 16'd0;
      power_up <= 1'b0;
      repeat (10) @(negedge sys_clk);
      chk("disable", {15'h0, pg_oe_n}, 16'h0);
      $display("parallel start test done");
   endtask : test_parallel
   task automatic test_phase;
      @(posedge sys_clk) ph4 <= 1'b1;
      repeat (20) @(negedge sys_clk);
      chk("phase before bias", {14'h0, ph_cnt}, {14'h0, PHASES_FOUR});
      @(posedge sys_clk) power_up <= 1'b1;
      repeat (12) @(negedge sys_clk);
      chk("three phase", {14'h0, ph_cnt}, {14'h0, PHASES_THREE});
      @(posedge sys_clk) power_up <= 1'b0;
      ph3 <= 1'b1;
      repeat (20) @(negedge sys_clk);
      @(posedge sys_clk) power_up <= 1'b1;
      repeat (12) @(negedge sys_clk);
      chk("two phase", {14'h0, ph_cnt}, {14'h0, PHASES_TWO});
      $display("phase detect test done");
   endtask : test_phase
   task automatic test_serial_prebias;
      @(posedge sys_clk) power_up <= 1'b1;
      for (n = 0; n < 20000 && core_ref < 16'd100; n++) @(negedge sys_clk);
      chk("ramp reached", core_ref, 16'd100);
      chk("prebias core off", {15'h0, core_drv}, 16'h0);
      chk("aux drive on", {15'h0, aux_drv}, 16'h1);
      wait_pg(1'b1, n);
      chk("core drive at end", {15'h0, core_drv}, 16'h1);
      chk("aux ref", aux_ref, 16'd200);
      chk("mode", {15'h0, ser_mode}, 16'h1);
      chk("phase kept", {14'h0, ph_cnt}, {14'h0, PHASES_TWO});
      @(posedge sys_clk) ser_core <= 16'd350;
      repeat (50) @(negedge sys_clk);
      chk("target held", core_ref, 16'd300);
      $display("serial prebias test done");
   endtask : test_serial_prebias
   task automatic test_ov;
      @(posedge sys_clk) diff_mv <= 16'd800;
      core_ov <= 1'b1;
      @(posedge sys_clk) core_ov <= 1'b0;
      repeat (25) @(negedge sys_clk);
      chk("clamp", {15'h0, ls_force}, 16'h1);
      chk("latched", {15'h0, latched}, 16'h1);
      @(posedge sys_clk) diff_mv <= 16'd300;
      repeat (5) @(negedge sys_clk);
      chk("clamp release", {15'h0, ls_force}, 16'h0);
      @(posedge sys_clk) power_up <= 1'b0;
      repeat (30) @(posedge sys_clk);
      power_up <= 1'b1;
      repeat (300) @(negedge sys_clk);
      chk("no restart", {15'h0, pg_oe_n}, 16'h0);
      @(posedge sys_clk) srst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      srst <= 1'b0;
      wait_pg(1'b1, n);
      chk("restart after reset", core_ref, 16'd350);
      $display("overvoltage test done");
   endtask : test_ov
   task automatic test_oc;
      int lo;
      lo = DLY + 350 * STEP;
      @(posedge sys_clk) core_oc <= 1'b1;
      @(posedge sys_clk) core_oc <= 1'b0;
      repeat (10) @(negedge sys_clk);
      chk("oc drives off", {14'h0, core_drv, pg_oe_n}, 16'h0);
      repeat (30) @(negedge sys_clk);
      chk("oc still waiting", core_ref, 16'h0);
      wait_pg(1'b1, n);
      chk("oc retry time", 16'(n >= lo && n <= lo + 50), 16'h1);
      @(posedge sys_clk) core_oc <= 1'b1;
      repeat (500) @(negedge sys_clk);
      chk("oc latch", {14'h0, latched, pg_oe_n}, 16'h2);
      $display("overcurrent test done");
   endtask : test_oc
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   initial begin
      {srst, power_up, mode_sel, ph3, ph4, core_ov, aux_ov, core_oc} = 8'h80;
      {par_tgt, ser_core, ser_aux, droop, diff_mv} = {16'd400, 16'd300, 16'd200, 32'h0};
      repeat (16) @(posedge sys_clk);
      srst <= 1'b0;
      @(negedge sys_clk);
      chk("reset power ok", {15'h0, pg_oe_n}, 16'h0);
      chk("reset pin level", {15'h0, pg_pin}, 16'h0);
      chk("reset phases", {12'h0, ph_cnt, pwm3, pwm4}, {12'h0, PHASES_FOUR, 2'h3});
      test_parallel();
      test_phase();
      test_serial_prebias();
      test_ov();
      test_oc();
      end_of_test();
   end
endmodule : tb_top
